/* rtl/fdcm_pkg.sv */
package fdcm_pkg;

  // Host register modes chosen by the straps at reset.
  typedef enum logic [1:0] {
    fdcm_basic,
    fdcm_enhanced,
    fdcm_compact
  } fdcm_mode_type;

  // Strap pins as seen after the input synchroniser.
  typedef struct packed {
    logic host_mode;
    logic encoding;
    logic polarity;
  } fdcm_strap_type;

  // Selections held from one reset release to the next.
  typedef struct packed {
    fdcm_mode_type mode;
    logic          host_mode;
    logic          polarity;
  } fdcm_sel_type;

  // Drive control register layout and reset value.
  localparam int        DC_GATE_BIT  = 3;
  localparam int        DC_MOTOR_LSB = 4;
  localparam int        DC_MOTORS    = 4;
  localparam logic [7:0] DC_RESET    = 8'h00;

  // Data rate codes and reset value.
  localparam logic [1:0] RATE_500K   = 2'h0;
  localparam logic [1:0] RATE_1M     = 2'h3;
  localparam logic [1:0] RATE_RESET  = 2'h0;

  // Host offsets of the two status registers.
  localparam logic [2:0] STAT_A_OFS  = 3'h0;
  localparam logic [2:0] STAT_B_OFS  = 3'h1;

  // Number of pins that pass the synchroniser.
  localparam int        PIN_COUNT    = 10;

endpackage : fdcm_pkg

/* rtl/fdcm_strap_latch.sv */
`timescale 1ns/1ps
module fdcm_strap_latch (
  // Clock and reset.
  input  wire logic           clk,
  input  wire logic           reset,
  // Settled straps and held selections.
  input  fdcm_pkg::fdcm_strap_type straps,
  output fdcm_pkg::fdcm_sel_type   sel
);
  import fdcm_pkg::*;

  fdcm_strap_type held_r;

  // Straps are followed while reset is high; the last value is kept.
  // latch at release
  always_ff @(posedge clk)
  begin
    if (reset)
      held_r <= straps;
  end

  // Host mode high always means basic, which also covers the illegal pair.
  // mode decode
  assign sel.mode      = held_r.host_mode ? fdcm_basic :
                         (held_r.encoding ? fdcm_enhanced : fdcm_compact);
  assign sel.host_mode = held_r.host_mode;
  assign sel.polarity  = held_r.polarity;

endmodule : fdcm_strap_latch

/* rtl/fdcm_sync3.sv */
`timescale 1ns/1ps
module fdcm_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock.
  input  wire logic             clk,
  // Asynchronous pins and their settled levels.
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  import fdcm_pkg::*;

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;

  // A bit moves only when the second and third stages agree.
  assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
  assign level_out = level_r;

  // Left without reset so that straps keep flowing while reset is held.
  always_ff @(posedge clk)
  begin
    s1_r    <= pin_in;
    s2_r    <= s1_r;
    s3_r    <= s2_r;
    level_r <= level_nxt;
  end

endmodule : fdcm_sync3

/* rtl/fdcm_top.sv */
`timescale 1ns/1ps
// Behaviour
// - Enhanced mode ignores the gate bit; request and interrupt always enabled.
// - Enhanced mode takes terminal count active low; status A and B readable.
// - Compact mode honours gate bit, terminal count high, status A/B readable.
// - Basic mode takes terminal count high, only while acknowledge is active.
// - Density select high-active when host strap high, else low, fast rates.
// - Interrupt rises when a reporting command finishes execution.
// - Interrupt also rises when a non-DMA data byte awaits the host.
// - Basic and compact modes gate interrupt with control bit D3.
// - Enhanced mode keeps interrupt enabled; D3 reserved.
// - Polarity strap low makes motor enable and index signals active low.
// - Polarity strap high makes motor enable and index active high; board buffers.
// - After reset the encoding pin drives format: high MFM, low FM.
// - Encoding format indication defaults low after reset.
// - Four motor enables follow control bits, drive 0 on D4.
// - Reset idles, deasserts disk outputs, clears control and rate registers.
module fdcm_top (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              reset,
  // Strap pins.
  input  wire logic              host_mode_pin,
  input  wire logic              polarity_strap,
  input  wire logic              encoding_mode_pin_in,
  output logic                   encoding_mode_pin_out,
  output logic                   encoding_mode_pin_oe,
  // Controller core side.
  input  wire logic              drive_control_write,
  input  wire logic [7:0]        drive_control_wdata,
  input  wire logic              rate_write,
  input  wire logic [1:0]        rate_wdata,
  input  wire logic              encoding_format_mfm,
  input  wire logic              command_done,
  input  wire logic              nondma_byte_ready,
  input  wire logic              core_dma_request,
  input  wire logic              interrupt_clear,
  input  wire logic [7:0]        status_reg_a,
  input  wire logic [7:0]        status_reg_b,
  output fdcm_pkg::fdcm_mode_type mode,
  output logic [7:0]             drive_control_register,
  output logic                   tc_accepted,
  output logic                   track_start,
  // Host bus pins.
  input  wire logic [2:0]        host_addr,
  input  wire logic              host_read_n,
  input  wire logic              dma_acknowledge_n,
  input  wire logic              terminal_count,
  output logic                   interrupt,
  output logic                   dma_request,
  output logic [7:0]             host_data_out,
  output logic                   host_data_oe,
  // Disk interface pins.
  input  wire logic              track_start_pin,
  output logic                   motor_enable_0,
  output logic                   motor_enable_1,
  output logic                   motor_enable_2,
  output logic                   motor_enable_3,
  output logic                   density_select
);
  import fdcm_pkg::*;

  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins_s;
  fdcm_strap_type       straps;
  fdcm_sel_type         sel;
  logic [2:0]           addr_s;
  logic                 read_s;
  logic                 dma_acknowledge_s;
  logic                 tc_s;
  logic                 index_s;

  logic [7:0]           dc_r;
  logic [7:0]           dc_nxt;
  logic [1:0]           rate_r;
  logic [1:0]           rate_nxt;
  logic                 pend_r;
  logic                 pend_nxt;
  logic                 int_r;
  logic                 int_nxt;
  logic                 drq_r;
  logic                 drq_nxt;
  logic                 tc_prev_r;
  logic                 tc_acc_r;
  logic                 idx_prev_r;
  logic                 trk_r;
  logic [DC_MOTORS-1:0] motor_r;
  logic [DC_MOTORS-1:0] motor_nxt;
  logic                 dens_r;
  logic                 dens_nxt;
  logic                 enc_out_r;
  logic                 enc_oe_r;
  logic [7:0]           dout_r;
  logic [7:0]           dout_nxt;
  logic                 doe_r;
  logic                 doe_nxt;

  logic                 enhanced;
  logic                 gate_open;
  logic                 tc_active;
  logic                 tc_hit;
  logic                 idx_active;
  logic                 dens_active;
  logic                 stat_hit;

  // Every pin from outside passes the three-stage synchroniser.
  assign pins_raw = {host_mode_pin, encoding_mode_pin_in, polarity_strap,
                     terminal_count, dma_acknowledge_n, host_read_n,
                     track_start_pin, host_addr};

  fdcm_sync3 #(
    .WIDTH (PIN_COUNT)
  ) u_sync (
    .clk       (clk),
    .pin_in    (pins_raw),
    .level_out (pins_s)
  );

  assign straps.host_mode = pins_s[9];
  assign straps.encoding  = pins_s[8];
  assign straps.polarity  = pins_s[7];
  assign tc_s             = pins_s[6];
  assign dma_acknowledge_s           = ~pins_s[5];
  assign read_s           = ~pins_s[4];
  assign index_s          = pins_s[3];
  assign addr_s           = pins_s[2:0];

  fdcm_strap_latch u_strap (
    .clk    (clk),
    .reset  (reset),
    .straps (straps),
    .sel    (sel)
  );

  // Mode decode shared by the gating below.
  assign enhanced  = (sel.mode == fdcm_enhanced);
  assign gate_open = enhanced | dc_r[DC_GATE_BIT];

  // Control and rate registers load from the core and clear on reset.
  // register clear
  assign dc_nxt   = drive_control_write ? drive_control_wdata : dc_r;
  assign rate_nxt = rate_write ? rate_wdata : rate_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dc_r   <= DC_RESET;
      rate_r <= RATE_RESET;
    end
    else
    begin
      dc_r   <= dc_nxt;
      rate_r <= rate_nxt;
    end
  end

  // Completion stays pending until cleared; a new completion wins.
  // completion interrupt
  assign pend_nxt = command_done | (pend_r & ~interrupt_clear);
  assign int_nxt  = (pend_nxt | nondma_byte_ready) & gate_open;
  assign drq_nxt  = core_dma_request & gate_open;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pend_r <= 1'b0;
      int_r  <= 1'b0;
      drq_r  <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      int_r  <= int_nxt;
      drq_r  <= drq_nxt;
    end
  end

  // Polarity of terminal count depends on the mode.
  // active low
  assign tc_active = enhanced ? ~tc_s : tc_s;
  assign tc_hit    = tc_active & dma_acknowledge_s;

  // Receivers invert when the polarity strap is low.
  // active low inputs
  assign idx_active = sel.polarity ? index_s : ~index_s;

  // Both detectors report only the first active cycle; clearing to the
  // idle level on reset makes a line already active at release report an edge.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tc_prev_r  <= 1'b0;
      tc_acc_r   <= 1'b0;
      idx_prev_r <= 1'b0;
      trk_r      <= 1'b0;
    end
    else
    begin
      tc_prev_r  <= tc_hit;
      tc_acc_r   <= tc_hit & ~tc_prev_r;
      idx_prev_r <= idx_active;
      trk_r      <= idx_active & ~idx_prev_r;
    end
  end

  // Each motor pin shows its control bit at the strap polarity.
  generate
    for (genvar k = 0; k < DC_MOTORS; k++)
    begin : g_motor
      assign motor_nxt[k] = ~(dc_r[DC_MOTOR_LSB + k] ^ sel.polarity);
    end
  endgenerate

  // Density select is active for the two fast rates only.
  // density polarity
  assign dens_active = (rate_r == RATE_500K) | (rate_r == RATE_1M);
  assign dens_nxt    = sel.host_mode ? dens_active : ~dens_active;

  // Pins sit at their inactive level while reset is held, and the
  // encoding pin stays an input so that its strap can still be read.
  // outputs inactive
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      motor_r   <= {DC_MOTORS{~sel.polarity}};
      dens_r    <= ~sel.host_mode;
      enc_oe_r  <= 1'b0;
      enc_out_r <= 1'b0;
    end
    else
    begin
      motor_r   <= motor_nxt;
      dens_r    <= dens_nxt;
      enc_oe_r  <= 1'b1;
      enc_out_r <= encoding_format_mfm;
    end
  end

  // Status reads are answered in the two register modes only.
  // basic stays undriven
  assign stat_hit = read_s & ~(sel.mode == fdcm_basic) &
                    ((addr_s == STAT_A_OFS) | (addr_s == STAT_B_OFS));
  assign doe_nxt  = stat_hit;
  assign dout_nxt = (addr_s == STAT_A_OFS) ? status_reg_a : status_reg_b;

  // Data only changes while driven, which keeps the bus quiet.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      doe_r  <= 1'b0;
      dout_r <= 8'h00;
    end
    else
    begin
      doe_r  <= doe_nxt;
      dout_r <= stat_hit ? dout_nxt : dout_r;
    end
  end

  // Output wiring.
  assign mode                   = sel.mode;
  assign drive_control_register = dc_r;
  assign tc_accepted            = tc_acc_r;
  assign track_start            = trk_r;
  assign interrupt              = int_r;
  assign dma_request            = drq_r;
  assign host_data_out          = dout_r;
  assign host_data_oe           = doe_r;
  assign motor_enable_0         = motor_r[0];
  assign motor_enable_1         = motor_r[1];
  assign motor_enable_2         = motor_r[2];
  assign motor_enable_3         = motor_r[3];
  assign density_select         = dens_r;
  assign encoding_mode_pin_out  = enc_out_r;
  assign encoding_mode_pin_oe   = enc_oe_r;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  enh_int_on_a: assert property (
    enhanced && command_done |=> interrupt)
    else $error("Enhanced mode completion did not interrupt.");
  tc_low_acc_a: assert property (
    tc_accepted |-> $past(tc_hit) && !$past(tc_prev_r))
    else $error("Count accepted without a fresh qualified edge.");
  drq_gate_a: assert property (
    !enhanced && !dc_r[DC_GATE_BIT] |=> !dma_request)
    else $error("Request driven while gate bit clear.");
  tc_dma_acknowledge_a: assert property (
    !dma_acknowledge_s |=> !tc_accepted)
    else $error("Count accepted without acknowledge.");
  basic_hiz_a: assert property (
    sel.mode == fdcm_basic |=> !host_data_oe)
    else $error("Data bus driven in basic mode.");
  dens_pol_a: assert property (
    rate_r == RATE_1M ##1 !$past(reset) |-> density_select == sel.host_mode)
    else $error("Density select at wrong level.");
  int_gate_a: assert property (
    !enhanced && !dc_r[DC_GATE_BIT] ##1 1 |-> !interrupt)
    else $error("Interrupt driven while gate bit clear.");
  motor_bit_a: assert property (
    $rose(dc_r[DC_MOTOR_LSB]) |=> motor_enable_0 == sel.polarity)
    else $error("Motor 0 did not follow its bit.");
  enc_drive_a: assert property (
    $fell(reset) |-> !encoding_mode_pin_oe ##1 encoding_mode_pin_oe)
    else $error("Encoding pin not driven after reset.");
  mode_hold_a: assert property (
    !$past(reset) |-> $stable(sel))
    else $error("Strap selections changed outside reset.");

endmodule : fdcm_top

/* test/fdcm_drive_model.sv */
`timescale 1ns/1ps
// Drive-side stand-in that swings the index line when asked.
module fdcm_drive_model (
  // Clock and controls.
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic polarity,
  input  wire logic fire,
  // Index line toward the device.
  output logic      index_pin
);
  logic [2:0] hold_r;

  // The pulse lasts six clocks so it outlives the input synchroniser.
  always_ff @(posedge clk)
  begin
    if (reset)
      hold_r <= 3'h0;
    else if (fire)
      hold_r <= 3'h6;
    else if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
  end

  // board-side buffers
  // The line rests at the inactive level of the chosen polarity.
  assign index_pin = (hold_r != 3'h0) ? polarity : ~polarity;
endmodule : fdcm_drive_model

/* test/fdcm_top_tb.sv */
`timescale 1ns/1ps
// Walks one strap setting for each of the three modes and checks the mode-driven behaviour.
module fdcm_top_tb;
  import fdcm_pkg::*;
  logic clk, reset, host_mode_pin, polarity_strap, enc_strap, fire, board_pol;
  logic drive_control_write, rate_write, encoding_format_mfm;
  logic command_done, nondma_byte_ready, core_dma_request;
  logic interrupt_clear, host_read_n, dma_acknowledge_n, terminal_count;
  logic [7:0] drive_control_wdata, status_reg_a, status_reg_b;
  logic [1:0] rate_wdata;
  logic [2:0] host_addr;
  wire logic encoding_mode_pin_in, track_start_pin;
  logic encoding_mode_pin_out, encoding_mode_pin_oe, tc_accepted;
  logic track_start, interrupt, dma_request, host_data_oe, density_select;
  logic motor_enable_0, motor_enable_1, motor_enable_2, motor_enable_3;
  logic [7:0] drive_control_register, host_data_out;
  fdcm_mode_type mode;
  int failures, checks_done, cycles, tc_cnt, trk_cnt;

  // The shared pin shows the strap until the device takes it over.
  assign encoding_mode_pin_in = encoding_mode_pin_oe ?
                                encoding_mode_pin_out : enc_strap;

  fdcm_top DUT (
    .clk, .reset, .host_mode_pin, .polarity_strap, .encoding_mode_pin_in,
    .encoding_mode_pin_out, .encoding_mode_pin_oe, .drive_control_write,
    .drive_control_wdata, .rate_write, .rate_wdata, .encoding_format_mfm,
    .command_done, .nondma_byte_ready, .core_dma_request, .interrupt_clear,
    .status_reg_a, .status_reg_b, .mode, .drive_control_register,
    .tc_accepted, .track_start, .host_addr, .host_read_n,
    .dma_acknowledge_n, .terminal_count, .interrupt, .dma_request,
    .host_data_out, .host_data_oe, .track_start_pin, .motor_enable_0,
    .motor_enable_1, .motor_enable_2, .motor_enable_3, .density_select
  );

  fdcm_drive_model drive (
    .clk(clk), .reset(reset), .polarity(board_pol), .fire(fire),
    .index_pin(track_start_pin)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pulse counters and the hang guard; the ceiling is about eight times a full run.
  always @(posedge clk)
  begin
    cycles++;
    if (tc_accepted === 1'b1)
      tc_cnt++;
    if (track_start === 1'b1)
      trk_cnt++;
    if (cycles == 3000)
    begin
      failures++;
      conclude();
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  // One-cycle core strobe: 0 control, 1 rate, 2 done, 3 clear.
  task automatic strobe(input int sel, input logic [7:0] v);
    @(posedge clk);
    drive_control_write <= (sel == 0);
    rate_write          <= (sel == 1);
    command_done        <= (sel == 2);
    interrupt_clear     <= (sel == 3);
    drive_control_wdata <= v;
    rate_wdata          <= v[1:0];
    @(posedge clk);
    {drive_control_write, rate_write, command_done, interrupt_clear} <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask : strobe

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  task automatic run_mode(input logic hm, input logic en, input logic pl,
                          input fdcm_mode_type em);
    logic tca;
    logic enh;
    tca = (em != fdcm_enhanced);
    enh = (em == fdcm_enhanced);
    @(posedge clk);
    host_mode_pin  <= hm;
    enc_strap      <= en;
    polarity_strap <= pl;
    board_pol      <= pl;
    terminal_count <= ~tca;
    reset          <= 1'b1;
    wait_n(8);
    chk_bit("int_rst", 1'b0, interrupt);
    chk_byte("dcr_rst", 8'h00, drive_control_register);
    chk_bit("motor_rst", ~pl, motor_enable_0);
    chk_bit("enc_oe_rst", 1'b0, encoding_mode_pin_oe);
    @(posedge clk);
    reset <= 1'b0;
    wait_n(2);
    // Straps move after release; the held selection must not follow.
    host_mode_pin  <= ~hm;
    polarity_strap <= ~pl;
    chk_bit("enc_oe", 1'b1, encoding_mode_pin_oe);
    chk_bit("enc_fm", 1'b0, encoding_mode_pin_out);
    chk_byte("mode", {6'h00, em}, {6'h00, mode});
    encoding_format_mfm <= 1'b1;
    wait_n(3);
    chk_bit("enc_mfm", 1'b1, encoding_mode_pin_out);
    encoding_format_mfm <= 1'b0;
    for (int a = 0; a < 2; a++)
    begin
      host_addr   <= 3'(a);
      host_read_n <= 1'b0;
      wait_n(8);
      chk_bit("data_oe", ~hm, host_data_oe);
      if (!hm)
        chk_byte("status", a ? status_reg_b : status_reg_a,
                 host_data_out);
    end
    host_read_n      <= 1'b1;
    core_dma_request <= 1'b1;
    strobe(0, 8'h50);
    chk_byte("dcr", 8'h50, drive_control_register);
    chk_bit("motor0", pl, motor_enable_0);
    chk_bit("motor1", ~pl, motor_enable_1);
    chk_bit("motor2", pl, motor_enable_2);
    chk_bit("motor3", ~pl, motor_enable_3);
    strobe(2, 8'h00);
    chk_bit("int_gated", enh, interrupt);
    chk_bit("drq_gated", enh, dma_request);
    strobe(0, 8'h08);
    chk_bit("int_open", 1'b1, interrupt);
    chk_bit("drq_open", 1'b1, dma_request);
    core_dma_request <= 1'b0;
    strobe(3, 8'h00);
    chk_bit("int_clr", 1'b0, interrupt);
    nondma_byte_ready <= 1'b1;
    wait_n(3);
    chk_bit("int_byte", 1'b1, interrupt);
    nondma_byte_ready <= 1'b0;
    strobe(1, 8'h00);
    chk_bit("dens_500k", hm, density_select);
    strobe(1, 8'h03);
    chk_bit("dens_1m", hm, density_select);
    strobe(1, 8'h01);
    chk_bit("dens_slow", ~hm, density_select);
    tc_cnt = 0;
    dma_acknowledge_n <= 1'b0;
    wait_n(6);
    terminal_count <= tca;
    wait_n(8);
    terminal_count    <= ~tca;
    dma_acknowledge_n <= 1'b1;
    wait_n(8);
    chk_byte("tc_taken", 8'h01, 8'(tc_cnt));
    terminal_count <= tca;
    wait_n(8);
    terminal_count <= ~tca;
    wait_n(8);
    chk_byte("tc_no_dma_acknowledge", 8'h01, 8'(tc_cnt));
    trk_cnt = 0;
    fire <= 1'b1;
    wait_n(1);
    fire <= 1'b0;
    wait_n(14);
    chk_byte("track", 8'h01, 8'(trk_cnt));
    $display("test mode %0d done, failures %0d", em, failures);
  endtask : run_mode

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    {reset, host_mode_pin, enc_strap, polarity_strap, fire} = 5'h10;
    board_pol = 1'b0;
    {drive_control_write, rate_write, command_done, interrupt_clear} = 4'h0;
    {encoding_format_mfm, nondma_byte_ready, core_dma_request} = 3'h0;
    {host_read_n, dma_acknowledge_n, terminal_count} = 3'h6;
    drive_control_wdata = 8'h00;
    rate_wdata          = 2'h0;
    host_addr           = 3'h0;
    status_reg_a        = 8'ha5;
    status_reg_b        = 8'h3c;
    repeat (5) @(posedge clk);
    run_mode(1'b1, 1'b1, 1'b0, fdcm_basic);
    run_mode(1'b0, 1'b1, 1'b1, fdcm_enhanced);
    run_mode(1'b0, 1'b0, 1'b0, fdcm_compact);
    conclude();
  end
endmodule : fdcm_top_tb
